// ===== logic/mopu_consts.vh
// register map, field positions and reset values of the pwm unit
// assumes a 32-bit avalon-mm slave with word addressing by byte address
`ifndef MOPU_CONSTS_VH
`define MOPU_CONSTS_VH
`define MOPU_ADDR_W 6
`define MOPU_OFF_CTRL 6'h00
`define MOPU_OFF_PRESC 6'h04
`define MOPU_OFF_COUNT 6'h08
`define MOPU_OFF_PCOUNT 6'h0c
`define MOPU_OFF_MCTRL 6'h10
`define MOPU_OFF_OUTSEL 6'h14
`define MOPU_OFF_LATCH 6'h18
`define MOPU_OFF_STATUS 6'h1c
`define MOPU_OFF_MASK 6'h20
`define MOPU_OFF_MATCH0 6'h24
`define MOPU_MATCH_IDX_W 3
`define MOPU_NMATCH 7
// control register bits
`define MOPU_CTRL_EN 0
`define MOPU_CTRL_RST 1
`define MOPU_CTRL_PWM 2
`define MOPU_CTRL_CNT 3
`define MOPU_CTRL_EDGE_LO 4
`define MOPU_CTRL_EDGE_HI 5
`define MOPU_CTRL_PIN 6
`define MOPU_CTRL_W 7
`define MOPU_EDGE_RISE 2'h0
`define MOPU_EDGE_FALL 2'h1
`define MOPU_EDGE_BOTH 2'h2
// per-match action bits: interrupt, reset, stop
`define MOPU_MCTRL_W 21
`define MOPU_ACT_W 3
`define MOPU_ACT_IRQ 0
`define MOPU_ACT_RST 1
`define MOPU_ACT_STOP 2
// output select: bits 1 to 5 double-edge mode (bit 0 unused), high 6 bits output enable
`define MOPU_OUTSEL_W 12
`define MOPU_OUTSEL_EN 6
`define MOPU_ZERO32 32'h00000000
`define MOPU_ONE32 32'h00000001
`endif

// ===== logic/mopu_top.v
// multi-output pwm unit: timer/counter, prescaler, seven match channels
// assumes an avalon-mm master on clock_i; capture pins are asynchronous
`include "mopu_consts.vh"
module mopu_top #(
    parameter NOUT = 6,
    parameter NCAP = 2
) (
    input wire clock_i,
    input wire reset_i,
    input wire [`MOPU_ADDR_W-1:0] address_i,
    input wire read_i,
    input wire write_i,
    input wire [31:0] writedata_i,
    input wire [3:0] byteenable_i,
    output reg [31:0] readdata_o,
    output wire waitrequest_o,
    input wire [NCAP-1:0] capture_i,
    output reg [NOUT-1:0] pwm_o,
    output wire irq_o
);

    // registers
    reg [`MOPU_CTRL_W-1:0] ctrl;
    reg [31:0] presc;
    reg [31:0] pcount;
    reg [31:0] count;
    reg [`MOPU_MCTRL_W-1:0] mctrl;
    reg [`MOPU_OUTSEL_W-1:0] outsel;
    reg [`MOPU_NMATCH-1:0] latch_en;
    reg [`MOPU_NMATCH-1:0] status;
    reg [`MOPU_NMATCH-1:0] mask;
    reg [32*`MOPU_NMATCH-1:0] shadow;
    reg [32*`MOPU_NMATCH-1:0] active;
    reg ack;

    // one wait state per access keeps read data registered
    assign waitrequest_o = (read_i | write_i) & ~ack;
    assign irq_o = |(status & mask);

    // capture pin synchroniser and edge detect
    reg [NCAP-1:0] cap_s1;
    reg [NCAP-1:0] cap_s2;
    reg [NCAP-1:0] cap_s3;
    always @(posedge clock_i) begin
        if (reset_i) begin
            cap_s1 <= {NCAP{1'b0}};
            cap_s2 <= {NCAP{1'b0}};
            cap_s3 <= {NCAP{1'b0}};
        end else begin
            cap_s1 <= capture_i;
            cap_s2 <= cap_s1;
            cap_s3 <= cap_s2;
        end
    end

    // counting tick: pclk in timer mode, selected pin edge in counter mode
    wire pin_now = cap_s2[ctrl[`MOPU_CTRL_PIN]];
    wire pin_old = cap_s3[ctrl[`MOPU_CTRL_PIN]];
    wire [1:0] edge_sel = ctrl[`MOPU_CTRL_EDGE_HI:`MOPU_CTRL_EDGE_LO];
    reg pin_edge;
    always @* begin
        if (edge_sel == `MOPU_EDGE_RISE)
            pin_edge = pin_now & ~pin_old;
        else if (edge_sel == `MOPU_EDGE_FALL)
            pin_edge = ~pin_now & pin_old;
        else
            pin_edge = pin_now ^ pin_old;
    end
    wire tick_src = ctrl[`MOPU_CTRL_CNT] ? pin_edge : 1'b1;
    wire run = ctrl[`MOPU_CTRL_EN] & ~ctrl[`MOPU_CTRL_RST];
    wire presc_done = (pcount == presc);
    wire tick = run & tick_src & presc_done;

    // compare each active match value with the counter
    wire [`MOPU_NMATCH-1:0] hit;
    genvar g;
    generate
        for (g = 0; g < `MOPU_NMATCH; g = g + 1) begin : gen_cmp
            assign hit[g] = tick & (active[32*g +: 32] == count);
        end
    endgenerate

    wire [`MOPU_NMATCH-1:0] act_irq;
    wire [`MOPU_NMATCH-1:0] act_rst;
    wire [`MOPU_NMATCH-1:0] act_stop;
    generate
        for (g = 0; g < `MOPU_NMATCH; g = g + 1) begin : gen_act
            assign act_irq[g] = mctrl[`MOPU_ACT_W*g + `MOPU_ACT_IRQ];
            assign act_rst[g] = mctrl[`MOPU_ACT_W*g + `MOPU_ACT_RST];
            assign act_stop[g] = mctrl[`MOPU_ACT_W*g + `MOPU_ACT_STOP];
        end
    endgenerate

    wire pwm_mode = ctrl[`MOPU_CTRL_PWM];
    // in pwm mode match zero always closes the cycle
    wire cycle_period_match = hit[0];
    wire do_reset = |(hit & act_rst) | (pwm_mode & cycle_period_match);
    wire do_stop = |(hit & act_stop);
    wire [`MOPU_NMATCH-1:0] irq_set = hit & act_irq;
    wire reload = pwm_mode & cycle_period_match;

    // bus access decode
    wire acc_wr = write_i & ack; // a write lands as waitrequest drops
    wire acc_rd = read_i & ~ack;
    wire [`MOPU_ADDR_W-1:0] a = address_i;
    wire in_match = (a >= `MOPU_OFF_MATCH0) &&
        (a < `MOPU_OFF_MATCH0 + 4*`MOPU_NMATCH);
    wire [`MOPU_ADDR_W-1:0] moff = a - `MOPU_OFF_MATCH0;
    wire [`MOPU_MATCH_IDX_W-1:0] midx = moff[`MOPU_MATCH_IDX_W+1:2];

    // byte-lane merge of write data over old value
    function [31:0] merge;
        input [31:0] old;
        input [31:0] dat;
        input [3:0] be;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (be[i])
                    merge[8*i +: 8] = dat[8*i +: 8];
        end
    endfunction

    // bus handshake: exactly one wait state per access
    always @(posedge clock_i) begin
        if (reset_i) begin
            ack <= 1'b0;
        end else begin
            ack <= (read_i | write_i) & ~ack;
        end
    end

    // prescaler and counter; a stop match still advances the count once
    always @(posedge clock_i) begin
        if (reset_i) begin
            pcount <= `MOPU_ZERO32;
            count <= `MOPU_ZERO32;
        end else if (ctrl[`MOPU_CTRL_RST]) begin
            pcount <= `MOPU_ZERO32;
            count <= `MOPU_ZERO32;
        end else if (run & tick_src) begin
            if (presc_done) begin
                pcount <= `MOPU_ZERO32;
                if (do_reset) begin
                    count <= `MOPU_ZERO32;
                end else begin
                    count <= count + `MOPU_ONE32;
                end
            end else begin
                pcount <= pcount + `MOPU_ONE32;
            end
        end
    end

    // configuration registers; a software write to control beats a stop
    always @(posedge clock_i) begin
        if (reset_i) begin
            ctrl <= {`MOPU_CTRL_W{1'b0}};
            presc <= `MOPU_ZERO32;
            mctrl <= {`MOPU_MCTRL_W{1'b0}};
            outsel <= {`MOPU_OUTSEL_W{1'b0}};
            mask <= {`MOPU_NMATCH{1'b0}};
        end else begin
            if (do_stop) begin
                ctrl[`MOPU_CTRL_EN] <= 1'b0;
            end
            if (acc_wr) begin
                if (a == `MOPU_OFF_CTRL) begin
                    ctrl <= writedata_i[`MOPU_CTRL_W-1:0];
                end else if (a == `MOPU_OFF_PRESC) begin
                    presc <= merge(presc, writedata_i, byteenable_i);
                end else if (a == `MOPU_OFF_MCTRL) begin
                    mctrl <= writedata_i[`MOPU_MCTRL_W-1:0];
                end else if (a == `MOPU_OFF_OUTSEL) begin
                    outsel <= writedata_i[`MOPU_OUTSEL_W-1:0];
                end else if (a == `MOPU_OFF_MASK) begin
                    mask <= writedata_i[`MOPU_NMATCH-1:0];
                end
            end
        end
    end

    // shadow match values: written freely, not yet in use by the compare
    always @(posedge clock_i) begin
        if (reset_i) begin
            shadow <= {32*`MOPU_NMATCH{1'b0}};
        end else if (acc_wr && in_match) begin
            shadow[32*midx +: 32] <= merge(shadow[32*midx +: 32],
                writedata_i, byteenable_i);
        end
    end

    // release bits; a release landing on a reload edge is kept
    always @(posedge clock_i) begin
        if (reset_i) begin
            latch_en <= {`MOPU_NMATCH{1'b0}};
        end else if (acc_wr && a == `MOPU_OFF_LATCH) begin
            latch_en <= (reload ? {`MOPU_NMATCH{1'b0}} : latch_en)
                | writedata_i[`MOPU_NMATCH-1:0];
        end else if (reload) begin
            latch_en <= {`MOPU_NMATCH{1'b0}};
        end
    end

    // active values: direct in timer mode, only at the cycle boundary in pwm
    // mode, so one cycle never mixes old and new edge positions
    integer k;
    always @(posedge clock_i) begin
        if (reset_i) begin
            active <= {32*`MOPU_NMATCH{1'b0}};
        end else begin
            for (k = 0; k < `MOPU_NMATCH; k = k + 1) begin
                if (!pwm_mode) begin
                    active[32*k +: 32] <= shadow[32*k +: 32];
                end else if (reload & latch_en[k]) begin
                    active[32*k +: 32] <= shadow[32*k +: 32];
                end
            end
        end
    end

    // match flags: a new event wins over a write-one-to-clear
    always @(posedge clock_i) begin
        if (reset_i) begin
            status <= {`MOPU_NMATCH{1'b0}};
        end else if (acc_wr && a == `MOPU_OFF_STATUS) begin
            status <= (status & ~writedata_i[`MOPU_NMATCH-1:0]) | irq_set;
        end else begin
            status <= status | irq_set;
        end
    end

    // read mux; unmapped addresses read zero
    reg [31:0] next_readdata;
    always @* begin
        if (a == `MOPU_OFF_CTRL) begin
            next_readdata = {{(32-`MOPU_CTRL_W){1'b0}}, ctrl};
        end else if (a == `MOPU_OFF_PRESC) begin
            next_readdata = presc;
        end else if (a == `MOPU_OFF_COUNT) begin
            next_readdata = count;
        end else if (a == `MOPU_OFF_PCOUNT) begin
            next_readdata = pcount;
        end else if (a == `MOPU_OFF_MCTRL) begin
            next_readdata = {{(32-`MOPU_MCTRL_W){1'b0}}, mctrl};
        end else if (a == `MOPU_OFF_OUTSEL) begin
            next_readdata = {{(32-`MOPU_OUTSEL_W){1'b0}}, outsel};
        end else if (a == `MOPU_OFF_LATCH) begin
            next_readdata = {{(32-`MOPU_NMATCH){1'b0}}, latch_en};
        end else if (a == `MOPU_OFF_STATUS) begin
            next_readdata = {{(32-`MOPU_NMATCH){1'b0}}, status};
        end else if (a == `MOPU_OFF_MASK) begin
            next_readdata = {{(32-`MOPU_NMATCH){1'b0}}, mask};
        end else if (in_match) begin
            next_readdata = shadow[32*midx +: 32];
        end else begin
            next_readdata = `MOPU_ZERO32;
        end
    end

    // read data taken in the first cycle, standing until the next read
    always @(posedge clock_i) begin
        if (reset_i) begin
            readdata_o <= `MOPU_ZERO32;
        end else if (acc_rd) begin
            readdata_o <= next_readdata;
        end
    end

    // output n: single edge sets at match zero, clears at match n+1;
    // double edge sets at match n, clears at match n+1
    wire [NOUT-1:0] next_pwm;
    generate
        for (g = 0; g < NOUT; g = g + 1) begin : gen_out
            // clear wins so a zero-width setting stays low
            wire dbl = (g > 0) & outsel[g];
            wire en = pwm_mode & outsel[`MOPU_OUTSEL_EN+g];
            wire set_ev = dbl ? hit[g] : cycle_period_match;
            wire clr_ev = hit[g+1];
            assign next_pwm[g] = en & ~clr_ev & (set_ev | pwm_o[g]);
        end
    endgenerate

    // registered outputs give the load glitch-free edges
    always @(posedge clock_i) begin
        if (reset_i) begin
            pwm_o <= {NOUT{1'b0}};
        end else begin
            pwm_o <= next_pwm;
        end
    end
endmodule

// ===== tb/mopu_load.sv
// external load model: measures high time and period of every pwm output
// assumes pwm_i is registered on clock_i, so one sample per cycle is exact
module mopu_load #(
    parameter NOUT = 6
) (
    input wire clock_i,
    input wire [NOUT-1:0] pwm_i,
    output logic [NOUT-1:0][15:0] high_o,
    output logic [NOUT-1:0][15:0] per_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [NOUT-1:0] prev = '0;
    logic [NOUT-1:0][15:0] hc = '0;
    logic [NOUT-1:0][15:0] pc = '0;
    initial high_o = '0;
    initial per_o = '0;
    // a rising edge closes the last pulse; values lag by one full cycle
    always @(posedge clock_i) begin
        for (int n = 0; n < NOUT; n++) begin
            if (pwm_i[n] && !prev[n]) begin
                high_o[n] <= hc[n];
                per_o[n] <= pc[n];
                hc[n] <= 16'h0001;
                pc[n] <= 16'h0001;
            end else begin
                pc[n] <= pc[n] + 16'h0001;
                hc[n] <= hc[n] + {15'h0000, pwm_i[n]};
            end
        end
        prev <= pwm_i;
    end
endmodule

// ===== tb/mopu_top_sva.sv
// port-level assertions for the pwm unit
// assumes one clock and a synchronous active-high reset
`include "mopu_consts.vh"
module mopu_sva #(
    parameter NOUT = 6,
    parameter NCAP = 2
) (
    input wire clock_i,
    input wire reset_i,
    input wire [`MOPU_ADDR_W-1:0] address_i,
    input wire read_i,
    input wire write_i,
    input wire [31:0] writedata_i,
    input wire [3:0] byteenable_i,
    input wire [31:0] readdata_o,
    input wire waitrequest_o,
    input wire [NCAP-1:0] capture_i,
    input wire [NOUT-1:0] pwm_o,
    input wire irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    reg pwm_h;
    reg [31:0] mask_h;
    // shadow of mode and mask, taken at accepted writes
    always @(posedge clock_i) begin
        if (reset_i) begin
            pwm_h <= 1'b0;
            mask_h <= 32'h00000000;
        end else if (write_i && !waitrequest_o && address_i == `MOPU_OFF_CTRL) begin
            pwm_h <= writedata_i[`MOPU_CTRL_PWM];
        end else if (write_i && !waitrequest_o && address_i == `MOPU_OFF_MASK) begin
            mask_h <= writedata_i;
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    sequence s_req_new;
        (read_i || write_i) && !$past(read_i || write_i);
    endsequence
    sequence s_req_wait;
        (read_i || write_i) && waitrequest_o;
    endsequence
    a_wait_first: assert property (s_req_new |-> waitrequest_o)
        else $error("new request without wait state");
    a_wait_once: assert property (s_req_wait |=> !waitrequest_o)
        else $error("more than one wait state");
    a_idle_wait: assert property (!(read_i || write_i) |-> !waitrequest_o)
        else $error("waitrequest high while idle");
    a_rst_pwm: assert property ($past(reset_i) |-> pwm_o == '0)
        else $error("pwm output not low after reset");
    a_rst_irq: assert property ($past(reset_i) |-> !irq_o)
        else $error("irq high after reset");
    a_read_hold: assert property (!(read_i && waitrequest_o) |=> $stable(readdata_o))
        else $error("read data changed without a read");
    a_pwm_off: assert property (!pwm_h && !$past(pwm_h) |-> pwm_o == '0)
        else $error("pwm output active in timer mode");
    a_irq_masked: assert property (mask_h == 32'h00000000 |-> !irq_o)
        else $error("irq high with all sources masked");
endmodule
bind mopu_top mopu_sva #(.NOUT(NOUT), .NCAP(NCAP)) u_mopu_sva (.clock_i(clock_i),
    .reset_i(reset_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .capture_i(capture_i), .pwm_o(pwm_o), .irq_o(irq_o));

// ===== tb/tb.sv
// register-level bench for the pwm unit with an output load model
// assumes an avalon slave with waitrequest that answers within 50 cycles
`include "mopu_consts.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic read_i = 1'b0;
    logic write_i = 1'b0;
    logic [5:0] address_i = 6'h00;
    logic [31:0] writedata_i = 32'h00000000;
    logic [1:0] capture_i = 2'h0;
    logic [31:0] q;
    wire [31:0] readdata_o;
    wire waitrequest_o;
    wire irq_o;
    wire [5:0] pwm_o;
    wire [5:0][15:0] hi;
    wire [5:0][15:0] per;
    int errors = 0;
    int checked = 0;
    mopu_top u_mopu_top (.clock_i(clock_i), .reset_i(reset_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(4'hf),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .capture_i(capture_i),
        .pwm_o(pwm_o), .irq_o(irq_o));
    mopu_load u_mopu_load (.clock_i(clock_i), .pwm_i(pwm_o), .high_o(hi), .per_o(per));
    // 25 MHz
    always #20 clock_i = ~clock_i;
    task automatic report_and_stop;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, e, g);
        end
    endtask
    // request stands until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_i);
        read_i <= !w;
        write_i <= w;
        address_i <= a;
        writedata_i <= d;
        do begin
            @(posedge clock_i);
            n++;
        end while (waitrequest_o !== 1'b0 && n < 50);
        q = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
        if (n >= 50) begin
            errors++;
            report_and_stop();
        end
    endtask
    task automatic rd(input logic [5:0] a, input string name, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        chk(name, e, q);
    endtask
    task automatic irq_is(input logic e);
        @(negedge clock_i);
        chk("irq", {31'h00000000, e}, {31'h00000000, irq_o});
    endtask
    task automatic pwm_is(input int n, input logic [15:0] h, input logic [15:0] p);
        chk("high", {16'h0000, h}, {16'h0000, hi[n]});
        chk("period", {16'h0000, p}, {16'h0000, per[n]});
    endtask
    initial begin
        repeat (8) @(posedge clock_i);
        reset_i <= 1'b0;
        rd(`MOPU_OFF_CTRL, "ctrl", 32'h00000000);
        // timer mode: prescale 2, stop with interrupt on match1
        bus(1'b1, `MOPU_OFF_PRESC, 32'h00000001);
        bus(1'b1, `MOPU_OFF_MATCH0 + 6'h04, 32'h00000004);
        bus(1'b1, `MOPU_OFF_MCTRL, 32'h00000028);
        bus(1'b1, `MOPU_OFF_MASK, 32'h00000002);
        bus(1'b1, `MOPU_OFF_CTRL, 32'h00000001);
        for (int n = 0; n < 200 && irq_o !== 1'b1; n++) @(negedge clock_i);
        if (irq_o !== 1'b1) begin
            errors++;
            report_and_stop();
        end
        irq_is(1'b1);
        // the stopping tick still advances the count past the match
        rd(`MOPU_OFF_COUNT, "count", 32'h00000005);
        rd(`MOPU_OFF_CTRL, "ctrl", 32'h00000000);
        chk("pwm", 32'h00000000, {26'h0, pwm_o});
        bus(1'b1, `MOPU_OFF_MASK, 32'h00000000);
        irq_is(1'b0);
        rd(`MOPU_OFF_STATUS, "status", 32'h00000002);
        bus(1'b1, `MOPU_OFF_MASK, 32'h00000002);
        irq_is(1'b1);
        bus(1'b1, `MOPU_OFF_STATUS, 32'h00000002);
        irq_is(1'b0);
        // counter mode on rising edges of capture pin 0
        bus(1'b1, `MOPU_OFF_MCTRL, 32'h00000000);
        bus(1'b1, `MOPU_OFF_PRESC, 32'h00000000);
        bus(1'b1, `MOPU_OFF_CTRL, 32'h00000002);
        bus(1'b1, `MOPU_OFF_CTRL, 32'h00000009);
        for (int i = 0; i < 5; i++) begin
            repeat (4) @(posedge clock_i);
            capture_i <= 2'h1;
            repeat (4) @(posedge clock_i);
            capture_i <= 2'h0;
        end
        repeat (6) @(posedge clock_i);
        rd(`MOPU_OFF_COUNT, "count", 32'h00000005);
        // counter mode on both edges of capture pin 1
        bus(1'b1, `MOPU_OFF_CTRL, 32'h00000002);
        bus(1'b1, `MOPU_OFF_CTRL, 32'h00000069);
        for (int i = 0; i < 3; i++) begin
            repeat (4) @(posedge clock_i);
            capture_i <= 2'h2;
            repeat (4) @(posedge clock_i);
            capture_i <= 2'h0;
        end
        repeat (6) @(posedge clock_i);
        rd(`MOPU_OFF_COUNT, "count", 32'h00000006);
        // pwm: period 10, out0 single, out1 double (negative pulse first)
        bus(1'b1, `MOPU_OFF_CTRL, 32'h00000002);
        bus(1'b1, `MOPU_OFF_MATCH0, 32'h00000009);
        bus(1'b1, `MOPU_OFF_MATCH0 + 6'h04, 32'h00000003);
        bus(1'b1, `MOPU_OFF_MATCH0 + 6'h08, 32'h00000002);
        bus(1'b1, `MOPU_OFF_OUTSEL, 32'h000000c2);
        bus(1'b1, `MOPU_OFF_LATCH, 32'h00000007);
        bus(1'b1, `MOPU_OFF_CTRL, 32'h00000005);
        repeat (40) @(posedge clock_i);
        pwm_is(0, 16'd4, 16'd10);
        pwm_is(1, 16'd9, 16'd10);
        bus(1'b1, `MOPU_OFF_MATCH0 + 6'h04, 32'h00000006);
        bus(1'b1, `MOPU_OFF_MATCH0 + 6'h08, 32'h00000008);
        repeat (30) @(posedge clock_i);
        pwm_is(0, 16'd4, 16'd10);
        pwm_is(1, 16'd9, 16'd10);
        bus(1'b1, `MOPU_OFF_LATCH, 32'h00000006);
        repeat (40) @(posedge clock_i);
        pwm_is(0, 16'd7, 16'd10);
        pwm_is(1, 16'd2, 16'd10);
        report_and_stop();
    end
endmodule
